//--- rtl/nac_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * NAND action and command sequencer.
 * Assumes a 10 MHz APB clock and 32-bit aligned register words.
 */
`ifndef NAC_REGS_SVH
`define NAC_REGS_SVH

// Register byte offsets
`define NAC_OFF_ACTION 8'h00
`define NAC_OFF_COMMAND 8'h04
`define NAC_OFF_COLUMN 8'h08
`define NAC_OFF_ROW 8'h0C
`define NAC_OFF_CONFIG 8'h10
`define NAC_OFF_STATUS 8'h14

// Action register fields
`define NAC_ACT_CODE_LSB 0
`define NAC_ACT_EXT_LSB 3
`define NAC_ACT_HOLD_BIT 3

// Configuration register fields and reset value
`define NAC_CFG_CARD_BIT 0
`define NAC_CFG_COUNT_LSB 1
`define NAC_CFG_UNITS_LSB 3
`define NAC_CFG_RESET 8'h00

// Status register fields
`define NAC_STA_RUN_BIT 0
`define NAC_STA_ILL_BIT 1
`define NAC_STA_HOLD_BIT 2
`define NAC_STA_DEV_LSB 3
`define NAC_STA_ZONE_LSB 5

// Flash bus phase times and their cycle counts at 10 MHz
`define NAC_CLK_NS 100
`define NAC_T_SETUP_NS 100
`define NAC_T_STROBE_NS 100
`define NAC_T_HOLD_NS 100
`define NAC_SETUP_CYC ((`NAC_T_SETUP_NS + `NAC_CLK_NS - 1) / `NAC_CLK_NS)
`define NAC_STROBE_CYC ((`NAC_T_STROBE_NS + `NAC_CLK_NS - 1) / `NAC_CLK_NS)
`define NAC_HOLD_CYC ((`NAC_T_HOLD_NS + `NAC_CLK_NS - 1) / `NAC_CLK_NS)

// Page geometry
`define NAC_UNIT_SHIFT 9
`define NAC_SPARE_SHIFT 4

`endif

//--- rtl/nac_pkg.sv
/*
 * Types shared by the NAND action and command sequencer.
 * Assumes nac_regs.svh carries the register and timing constants; action and state codes are set here.
 */
`default_nettype none
package nac_pkg;

   // Action codes written to the low three bits of action_launch
   typedef enum logic [2:0] {
      NAC_ACT_NONE = 3'b000,
      NAC_ACT_SELECT = 3'b001,
      NAC_ACT_READ = 3'b010,
      NAC_ACT_WRITE = 3'b011,
      NAC_ACT_HOLD = 3'b100,
      NAC_ACT_STOP = 3'b101,
      NAC_ACT_COLEXT = 3'b110,
      NAC_ACT_RSVD = 3'b111
   } nac_action_t;

   // Flash bus cycle sequencer
   typedef enum logic [1:0] {
      NAC_ST_IDLE = 2'b00,
      NAC_ST_SETUP = 2'b01,
      NAC_ST_STROBE = 2'b10,
      NAC_ST_HOLD = 2'b11
   } nac_state_t;

   // Static configuration
   typedef struct packed {
      logic [4:0] page_data_units;
      logic [1:0] device_count_minus_one;
      logic card_mode_enable;
   } nac_cfg_t;

   // Flash bus strobes and byte
   typedef struct packed {
      logic cle;
      logic ale;
      logic we_n;
      logic io_oe;
      logic [7:0] io_out;
   } nac_fbus_t;

endpackage
`default_nettype wire

//--- rtl/nac_sequencer.sv
/*
 * NAND flash action and command sequencer: APB register slave, action
 * decoder, device select and chip-enable control, command and address
 * bus cycles, in-page byte counter and session control.
 * Assumes a data flow controller on the same clock strobes each page byte,
 * and that the flash I/O wire is resolved outside from io_oe.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
`default_nettype none
`include "nac_regs.svh"

module nac_sequencer
   import nac_pkg::*;
#(
   parameter int CNT_W = 15,
   parameter int ROW_W = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dfc_byte_strobe,
   output logic dfc_flow_enable,
   output logic session_is_write,
   output logic spare_zone_active,
   output logic [CNT_W-1:0] page_byte_count,
   output logic [ROW_W-1:0] protect_row,
   output logic protect_row_valid,
   output logic ecc_reinit,
   output logic illegal_event,
   output logic running_flag,
   output logic [3:0] flash_chip_enable_n,
   output nac_fbus_t flash_bus
);

   localparam logic [1:0] SETUP_CYC = 2'(`NAC_SETUP_CYC);
   localparam logic [1:0] STROBE_CYC = 2'(`NAC_STROBE_CYC);
   localparam logic [1:0] HOLD_CYC = 2'(`NAC_HOLD_CYC);
   localparam logic [1:0] CARD_POS = 2'h3;

   // APB decode
   wire logic access = psel & penable;
   wire logic wr = access & pwrite;
   wire logic rd = access & ~pwrite;
   wire logic hit_act = paddr == `NAC_OFF_ACTION;
   wire logic hit_cmd = paddr == `NAC_OFF_COMMAND;
   wire logic hit_col = paddr == `NAC_OFF_COLUMN;
   wire logic hit_row = paddr == `NAC_OFF_ROW;
   wire logic hit_cfg = paddr == `NAC_OFF_CONFIG;
   wire logic hit_sta = paddr == `NAC_OFF_STATUS;
   wire logic mapped = hit_act | hit_cmd | hit_col | hit_row | hit_cfg |
                       hit_sta;

   // State
   nac_state_t state_q, state_d;
   logic [1:0] phase_cnt_q;
   nac_cfg_t cfg_q;
   logic [1:0] dev_q;
   logic hold_q;
   logic [1:0] zone_q;
   logic session_q;
   logic sess_wr_q;
   logic stop_q;
   logic ill_sticky_q;
   logic illegal_q;
   logic ecc_q;
   logic [CNT_W-1:0] cnt_q;
   logic col_idx_q;
   logic [1:0] row_idx_q;
   logic [ROW_W-1:0] row_q;
   logic row_valid_q;
   nac_fbus_t bus_q;

   // Running while a bus cycle or a page session is in progress
   // An open page counts as running, so stray action and bus writes are refused
   wire logic busy = (state_q != NAC_ST_IDLE) | session_q;

   wire logic [7:0] wbyte = pwdata[7:0];
   wire nac_action_t act_code = nac_action_t'(wbyte[2:0]);
   wire logic [1:0] act_ext = wbyte[`NAC_ACT_EXT_LSB +: 2];
   wire logic act_wr = wr & hit_act;
   wire logic cmd_wr = wr & hit_cmd;
   wire logic col_wr = wr & hit_col;
   wire logic row_wr = wr & hit_row;
   wire logic bus_wr = cmd_wr | col_wr | row_wr;

   // none and reserved are not events; stop is the abort path
   wire logic act_event = act_wr & (act_code != NAC_ACT_NONE) &
                          (act_code != NAC_ACT_RSVD) &
                          (act_code != NAC_ACT_STOP);
   wire logic refused = busy & (act_event | bus_wr);

   wire logic dev_ok_nf = act_ext <= cfg_q.device_count_minus_one;
   wire logic dev_ok_card = (act_ext == CARD_POS) |
                            (act_ext < cfg_q.device_count_minus_one);
   wire logic dev_ok = cfg_q.card_mode_enable ? dev_ok_card : dev_ok_nf;
   wire logic sel_go = act_wr & ~busy & (act_code == NAC_ACT_SELECT);
   wire logic sel_bad = sel_go & ~dev_ok;

   // Accepted events
   wire logic go_sel = sel_go & dev_ok;
   wire logic go_rd = act_wr & ~busy & (act_code == NAC_ACT_READ);
   wire logic go_wrs = act_wr & ~busy & (act_code == NAC_ACT_WRITE);
   wire logic go_hold = act_wr & ~busy & (act_code == NAC_ACT_HOLD);
   wire logic go_ext = act_wr & ~busy & (act_code == NAC_ACT_COLEXT);
   wire logic go_stop = act_wr & (act_code == NAC_ACT_STOP);
   wire logic go_bus = bus_wr & ~busy;

   // page end: data units of 512 plus 16 spare bytes per unit
   wire logic [CNT_W-1:0] data_end =
      CNT_W'({cfg_q.page_data_units, 9'h000});
   wire logic [CNT_W-1:0] page_end =
      data_end + CNT_W'({cfg_q.page_data_units, 4'h0});
   // single column cycle only for one-unit pages
   wire logic one_col = cfg_q.page_data_units == 5'h01;

   // page finished when counter reaches page end
   wire logic page_done = session_q & dfc_byte_strobe &
                          (cnt_q + CNT_W'(1) >= page_end);
   wire logic bus_done = (state_q == NAC_ST_HOLD) &
                         (phase_cnt_q == HOLD_CYC - 2'h1);

   // Bus cycle sequencer; each phase lasts its own count
   always_comb begin
      state_d = state_q;
      case (state_q)
         NAC_ST_IDLE: begin
            if (go_bus) begin
               state_d = NAC_ST_SETUP;
            end
         end
         NAC_ST_SETUP: begin
            if (phase_cnt_q == SETUP_CYC - 2'h1) begin
               state_d = NAC_ST_STROBE;
            end
         end
         NAC_ST_STROBE: begin
            if (phase_cnt_q == STROBE_CYC - 2'h1) begin
               state_d = NAC_ST_HOLD;
            end
         end
         NAC_ST_HOLD: begin
            if (bus_done) begin
               state_d = NAC_ST_IDLE;
            end
         end
         default: begin
            state_d = NAC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= NAC_ST_IDLE;
         phase_cnt_q <= 2'h0;
      end else begin
         state_q <= state_d;
         phase_cnt_q <= (state_d != state_q) ? 2'h0 : phase_cnt_q + 2'h1;
      end
   end

   // flash bus byte and latch strobes, held for the whole cycle
   // Byte and latches stand still around the write pulse for setup and hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_q <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, io_oe: 1'b0,
                    io_out: 8'h00};
      end else if (go_bus) begin
         bus_q <= '{cle: cmd_wr, ale: ~cmd_wr, we_n: 1'b1, io_oe: 1'b1,
                    io_out: wbyte};
      end else if (state_d == NAC_ST_STROBE) begin
         bus_q.we_n <= 1'b0;
      end else if (state_d == NAC_ST_HOLD) begin
         bus_q.we_n <= 1'b1;
      end else if (state_d == NAC_ST_IDLE) begin
         bus_q <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, io_oe: 1'b0,
                    io_out: 8'h00};
      end
   end

   // Configuration register steers selection and page geometry
   // Geometry is not guarded; software must stop a session before changing it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= nac_cfg_t'(`NAC_CFG_RESET);
      end else if (wr & hit_cfg) begin
         cfg_q.card_mode_enable <= wbyte[`NAC_CFG_CARD_BIT];
         cfg_q.device_count_minus_one <= wbyte[`NAC_CFG_COUNT_LSB +: 2];
         cfg_q.page_data_units <= wbyte[`NAC_CFG_UNITS_LSB +: 5];
      end
   end

   // device select kept until the next select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_q <= 2'h0;
         hold_q <= 1'b0;
      end else begin
         if (go_sel) begin
            dev_q <= act_ext;
         end
         // hold bit from the hold action
         if (go_hold) begin
            hold_q <= wbyte[`NAC_ACT_HOLD_BIT];
         end
      end
   end

   // zone selector: extension loads it, column access clears it
   // The column write still sees the old zone on the edge that clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zone_q <= 2'h0;
      end else if (access & hit_col) begin
         zone_q <= 2'h0;
      end else if (go_ext) begin
         zone_q <= act_ext;
      end
   end

   // page session; stop ends it once the flash cycle is done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         session_q <= 1'b0;
         sess_wr_q <= 1'b0;
         stop_q <= 1'b0;
      end else begin
         if (go_rd | go_wrs) begin
            session_q <= 1'b1;
            sess_wr_q <= go_wrs;
         end else if (page_done |
                      ((stop_q | go_stop) & (state_q == NAC_ST_IDLE))) begin
            session_q <= 1'b0;
         end
         // Stop waits for a running bus cycle to finish before halting
         if (go_stop & (state_q != NAC_ST_IDLE)) begin
            stop_q <= 1'b1;
         end else if (state_q == NAC_ST_IDLE) begin
            stop_q <= 1'b0;
         end
      end
   end

   // column counter; a write while busy is refused outright
   // Two-cycle pages take the low byte first, then the high byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         col_idx_q <= 1'b0;
      end else if (access & hit_cmd) begin
         cnt_q <= '0;
         col_idx_q <= 1'b0;
      end else if (col_wr & ~busy) begin
         if (one_col) begin
            cnt_q <= CNT_W'({zone_q, wbyte});
         end else if (!col_idx_q) begin
            cnt_q <= {cnt_q[CNT_W-1:8], wbyte};
            col_idx_q <= 1'b1;
         end else begin
            cnt_q <= {wbyte[CNT_W-9:0], cnt_q[7:0]};
            col_idx_q <= 1'b0;
         end
      end else if (session_q & dfc_byte_strobe) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // row capture for the protection check, low byte first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_q <= '0;
         row_idx_q <= 2'h0;
         row_valid_q <= 1'b0;
      end else if (access & hit_cmd) begin
         row_q <= '0;
         row_idx_q <= 2'h0;
         row_valid_q <= 1'b0;
      end else if (row_wr & ~busy) begin
         row_q[row_idx_q*8 +: 8] <= wbyte;
         row_idx_q <= (row_idx_q == 2'h2) ? 2'h0 : row_idx_q + 2'h1;
         row_valid_q <= 1'b1;
      end
   end

   // illegal pulse and sticky copy; a new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illegal_q <= 1'b0;
         ill_sticky_q <= 1'b0;
         ecc_q <= 1'b0;
      end else begin
         illegal_q <= refused | sel_bad;
         if (refused | sel_bad) begin
            ill_sticky_q <= 1'b1;
         end else if (wr & hit_sta & wbyte[`NAC_STA_ILL_BIT]) begin
            ill_sticky_q <= 1'b0;
         end
         // ECC engine and FIFO restart on each command write accepted while idle
         ecc_q <= cmd_wr & ~busy;
      end
   end

   // chip enables: held device or device of a running command
   // Enables decode dev_q directly, so a select under hold swaps them at once
   wire logic ce_on = hold_q | busy;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_ce
         assign flash_chip_enable_n[g] = ~(ce_on & (dev_q == 2'(g)));
      end
   endgenerate

   // Status word; write-only registers read as zero
   wire logic [7:0] status_byte = {1'b0, zone_q, dev_q, hold_q,
                                   ill_sticky_q, busy};
   wire logic [7:0] cfg_byte = {cfg_q.page_data_units,
                                cfg_q.device_count_minus_one,
                                cfg_q.card_mode_enable};
   assign prdata = hit_sta ? {24'h00_0000, status_byte} :
                   hit_cfg ? {24'h00_0000, cfg_byte} : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // running flag low when idle; session outputs
   assign running_flag = busy;
   assign dfc_flow_enable = session_q;
   assign session_is_write = sess_wr_q;
   assign spare_zone_active = session_q & (cnt_q >= data_end);
   assign page_byte_count = cnt_q;
   assign protect_row = row_q;
   assign protect_row_valid = row_valid_q;
   assign ecc_reinit = ecc_q;
   assign illegal_event = illegal_q;
   assign flash_bus = bus_q;

endmodule // nac_sequencer
`default_nettype wire

//--- tb/nac_flash_model.sv
/*
 * Behavioural flash devices behind the sequencer's strobes.
 * Assumes the strobes are registered on the same pclk.
 */
`default_nettype none
module nac_flash_model
   import nac_pkg::*;
(
   input wire logic pclk,
   input wire nac_fbus_t fb,
   input wire logic [3:0] ce_n,
   input wire logic card_en,
   output logic [7:0] last_byte,
   output logic [1:0] last_kind,
   output logic card_hit,
   output int cmd_cnt,
   output int addr_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic we_q = 1'b1;
   int cmd_q = 0;
   int addr_q = 0;

   // Counters live in one shared process; ports only mirror them
   assign cmd_cnt = cmd_q;
   assign addr_cnt = addr_q;

   // Latch on the write strobe's rising edge, as a real part does
   always @(posedge pclk) begin
      we_q <= fb.we_n;
      if (!we_q && fb.we_n === 1'b1 && ce_n !== 4'hf) begin
         last_byte <= fb.io_out;
         last_kind <= {fb.cle, fb.ale};
         card_hit <= card_en && !ce_n[3];
         // address cycles, column and row alike, are counted one by one
         if (fb.ale) addr_q <= addr_q + 1;
         if (fb.cle) cmd_q <= cmd_q + 1;
      end
   end
endmodule // nac_flash_model
`default_nettype wire

//--- tb/nac_sequencer_chk.sv
/*
 * Assertions on the sequencer's ports.
 * Assumes one pclk domain with presetn as its reset.
 */
`default_nettype none
`include "nac_regs.svh"
module nac_sequencer_chk
   import nac_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic dfc_flow_enable,
   input wire logic session_is_write,
   input wire logic ecc_reinit,
   input wire logic illegal_event,
   input wire logic running_flag,
   input wire logic [3:0] flash_chip_enable_n,
   input wire nac_fbus_t flash_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   logic acc, wcmd, wadr, wact;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Accepted writes by target; acceptance ignores running_flag here
   assign acc = psel && penable && pwrite;
   assign wcmd = acc && paddr == `NAC_OFF_COMMAND;
   assign wadr = acc && (paddr == `NAC_OFF_COLUMN || paddr == `NAC_OFF_ROW);
   assign wact = acc && paddr == `NAC_OFF_ACTION;

   a_idle_after_reset: assert property (
      $rose(presetn) |-> !running_flag && flash_chip_enable_n == 4'hf)
      else $error("not idle after reset");
   a_cmd_cycle: assert property (
      wcmd && !running_flag |=> flash_bus.cle && !flash_bus.ale &&
      flash_bus.io_oe && flash_bus.io_out == $past(pwdata[7:0]))
      else $error("command cycle wrong");
   a_cmd_strobe_order: assert property (
      wcmd && !running_flag |=> flash_bus.we_n ##1 !flash_bus.we_n ##1
      flash_bus.we_n ##1 (!flash_bus.cle && !running_flag))
      else $error("command strobe order wrong");
   a_ecc_reinit: assert property (
      wcmd && !running_flag |=> ecc_reinit)
      else $error("no ecc reinit pulse");
   a_addr_cycle: assert property (
      wadr && !running_flag |=> flash_bus.ale && !flash_bus.cle &&
      flash_bus.io_out == $past(pwdata[7:0]))
      else $error("address cycle wrong");
   a_busy_refused: assert property (
      (wcmd || wadr) && running_flag |=> illegal_event)
      else $error("busy event not refused");
   a_ce_during_cycle: assert property (
      flash_bus.cle || flash_bus.ale |-> $onehot(~flash_chip_enable_n))
      else $error("no single enable in bus cycle");
   a_ce_single: assert property (
      $onehot0(~flash_chip_enable_n))
      else $error("two enables low");
   a_session_open: assert property (
      wact && !running_flag && pwdata[2:1] == 2'b01 |=> dfc_flow_enable &&
      running_flag && session_is_write == $past(pwdata[0]))
      else $error("session not opened");
   a_stop_closes: assert property (
      wact && pwdata[2:0] == 3'b101 && dfc_flow_enable |=>
      ##[0:4] (!running_flag && !dfc_flow_enable))
      else $error("stop did not close");
   a_none_quiet: assert property (
      wact && !running_flag && (pwdata[2:0] == 3'b000 ||
      pwdata[2:0] == 3'b111) |=> !illegal_event &&
      $stable(flash_chip_enable_n))
      else $error("no-op action had effect");
endmodule // nac_sequencer_chk
bind nac_sequencer nac_sequencer_chk nac_sequencer_chk_inst (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .dfc_flow_enable,
   .session_is_write, .ecc_reinit, .illegal_event, .running_flag,
   .flash_chip_enable_n, .flash_bus);
`default_nettype wire

//--- tb/nac_sequencer_tb.sv
/*
 * Register-level testbench of the sequencer with flash model.
 * Assumes pready answers within the watchdog span.
 */
`default_nettype none
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin \
   fail_count++; $display("wrong value %s exp %0h got %0h", n, x, g); end end
module nac_sequencer_tb
   import nac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, m_byte;
   logic [31:0] pwdata, prdata, r;
   logic dfc_byte_strobe, dfc_flow_enable, session_is_write;
   logic spare_zone_active, protect_row_valid, ecc_reinit;
   logic illegal_event, running_flag, m_card, card_en;
   logic [14:0] page_byte_count;
   logic [23:0] protect_row;
   logic [3:0] flash_chip_enable_n;
   logic [1:0] m_kind;
   nac_fbus_t flash_bus;
   int fail_count, samples_checked, k, n, m_cmd, m_addr;

   nac_sequencer nac_sequencer_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dfc_byte_strobe,
      .dfc_flow_enable, .session_is_write, .spare_zone_active,
      .page_byte_count, .protect_row, .protect_row_valid, .ecc_reinit,
      .illegal_event, .running_flag, .flash_chip_enable_n, .flash_bus);
   nac_flash_model nac_flash_model_inst (.pclk, .fb(flash_bus),
      .ce_n(flash_chip_enable_n), .card_en, .last_byte(m_byte),
      .last_kind(m_kind), .card_hit(m_card), .cmd_cnt(m_cmd),
      .addr_cnt(m_addr));

   // Clock at 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // One APB transfer; read data is taken at the pready edge, before the
   // design's own updates land; the idle edge after release lets them show
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Wait for the bus cycle to finish, bounded
   task automatic idle();
      for (k = 0; k < 20 && running_flag !== 1'b0; k++) @(posedge pclk);
      if (running_flag !== 1'b0) begin
         fail_count++;
         final_report();
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog, well beyond the fewer than a thousand cycles the tests take
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report();
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, dfc_byte_strobe, card_en} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fail_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("enables", 4'hf, flash_chip_enable_n)
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("status", 32'h0000_0000, r)
      apb(0, 8'h18, 32'h0000_0000);
      `CHK("slverr", 1'b1, e)
      apb(1, 8'h10, 32'h0000_000E);
      apb(0, 8'h10, 32'h0000_0000);
      `CHK("config", 8'h0E, r[7:0])
      for (n = 0; n < 4; n++) begin
         apb(1, 8'h00, 32'(n * 8 + 1));
         apb(0, 8'h14, 32'h0000_0000);
         `CHK("device", n[1:0], r[4:3])
         `CHK("illegal", 1'b0, r[1])
      end
      // Card on with three devices: 3, 0 and 1 allowed
      card_en <= 1'b1;
      apb(1, 8'h10, 32'h0000_000D);
      apb(1, 8'h00, 32'h0000_0011);
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("bad target", 1'b1, r[1])
      `CHK("device kept", 2'd3, r[4:3])
      apb(1, 8'h14, 32'h0000_0002);
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("illegal cleared", 1'b0, r[1])
      apb(1, 8'h00, 32'h0000_000C);
      `CHK("hold enable", 4'h7, flash_chip_enable_n)
      apb(1, 8'h04, 32'h0000_0090);
      apb(1, 8'h04, 32'h0000_0091);
      idle();
      `CHK("cmd byte", 8'h90, m_byte)
      `CHK("cmd kind", 2'b10, m_kind)
      `CHK("card hit", 1'b1, m_card)
      `CHK("cmd count", 1, m_cmd)
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("busy refused", 1'b1, r[1])
      apb(1, 8'h00, 32'h0000_0001);
      `CHK("hold moves", 4'he, flash_chip_enable_n)
      apb(1, 8'h00, 32'h0000_0004);
      apb(1, 8'h04, 32'h0000_0070);
      `CHK("auto enable", 4'he, flash_chip_enable_n)
      idle();
      `CHK("auto release", 4'hf, flash_chip_enable_n)
      apb(1, 8'h00, 32'h0000_0016);
      apb(1, 8'h04, 32'h0000_0070);
      idle();
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("zone kept", 2'b10, r[6:5])
      apb(1, 8'h08, 32'h0000_0012);
      idle();
      `CHK("col byte", 8'h12, m_byte)
      `CHK("col kind", 2'b01, m_kind)
      `CHK("col cycles", 1, m_addr)
      `CHK("counter", 15'h0212, page_byte_count)
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("zone reset", 2'b00, r[6:5])
      apb(1, 8'h00, 32'h0000_000E);
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("zone second half", 2'b01, r[6:5])
      // read data of the column register is never used
      apb(0, 8'h08, 32'h0000_0000);
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("zone read reset", 2'b00, r[6:5])
      apb(1, 8'h0C, 32'h0000_0034);
      idle();
      `CHK("row", 8'h34, protect_row[7:0])
      `CHK("row valid", 1'b1, protect_row_valid)
      apb(1, 8'h04, 32'h0000_0000);
      idle();
      `CHK("row cleared", 1'b0, protect_row_valid)
      apb(1, 8'h08, 32'h0000_0000);
      idle();
      apb(1, 8'h00, 32'h0000_0002);
      `CHK("read flow", 1'b1, dfc_flow_enable)
      `CHK("read dir", 1'b0, session_is_write)
      // Stream one page of 528 bytes; the session must end itself
      // At each edge the counter seen still lacks the strobe taken there
      for (n = 0; n < 600 && running_flag === 1'b1; n++) begin
         dfc_byte_strobe <= 1'b1;
         @(posedge pclk);
         if (n == 511 || n == 512)
            `CHK("spare", n == 512, spare_zone_active)
      end
      dfc_byte_strobe <= 1'b0;
      // The close is seen one edge late, so one strobe lands after it
      `CHK("page bytes", 528, n - 1)
      apb(1, 8'h00, 32'h0000_0003);
      `CHK("write dir", 1'b1, session_is_write)
      apb(1, 8'h00, 32'h0000_0005);
      idle();
      `CHK("stopped", 1'b0, running_flag)
      `CHK("flow off", 1'b0, dfc_flow_enable)
      // Two-unit pages take the column in two bytes, low byte first
      apb(1, 8'h10, 32'h0000_0015);
      n = m_addr;
      apb(1, 8'h08, 32'h0000_0034);
      idle();
      apb(1, 8'h08, 32'h0000_0001);
      idle();
      `CHK("col two cycles", n + 2, m_addr)
      `CHK("col two bytes", 15'h0134, page_byte_count)
      // No-op codes under hold on the card position must change nothing
      apb(1, 8'h00, 32'h0000_0019);
      apb(1, 8'h00, 32'h0000_000C);
      apb(1, 8'h00, 32'h0000_0007);
      apb(1, 8'h00, 32'h0000_0000);
      apb(0, 8'h14, 32'h0000_0000);
      `CHK("no-op state", 5'b00111, r[6:2])
      `CHK("no-op enable", 4'h7, flash_chip_enable_n)
      final_report();
   end
endmodule // nac_sequencer_tb
`default_nettype wire
